// ===== verilog/mic_regs.svh
// Timing counts and field positions of the serial microphone link.
// Assumes a 25 MHz system clock at both ends; included by bare name.
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

`define MIC_CLK_HZ 25000000
`define MIC_FRAME_BITS 64
`define MIC_HALF_BITS 32
`define MIC_WORD_BITS 24
`define MIC_PREC_BITS 18
`define MIC_DECIM 64
// Active threshold 1 MHz: a bit clock period longer than this is too slow
`define MIC_ACTIVE_HZ 1000000
`define MIC_ACTIVE_CYC (`MIC_CLK_HZ / `MIC_ACTIVE_HZ)
// Sleep threshold 1 kHz: no rising edge for this long means stopped
`define MIC_SLEEP_HZ 1000
`define MIC_SLEEP_CYC (`MIC_CLK_HZ / `MIC_SLEEP_HZ)
// Wake settle time 50 ms
`define MIC_WAKE_MS 50
`define MIC_WAKE_CYC (`MIC_CLK_HZ / 1000 * `MIC_WAKE_MS)
// Host bit clock divider: half period in system cycles (320 ns period)
`define MIC_HOST_HALF 4

`endif

// ===== verilog/mic_pkg.sv
// Types shared by both ends of the serial microphone link.
// Assumes nothing beyond a SystemVerilog compiler.
package mic_pkg;
	typedef enum logic [1:0] {
		MIC_SLEEP = 2'b00,
		MIC_WAKE = 2'b01,
		MIC_ACTIVE = 2'b11
	} mic_mode_t;
	typedef logic [23:0] mic_word_t;
endpackage

// ===== verilog/mic_if.sv
// Link wires between the microphone and its bus master.
// Resolves the data wire from the enable here, so the bench needs no logic for it.
`timescale 1ns/1ps
interface mic_if;
	logic bclk;
	logic ws;
	logic data_o;
	logic data_oe;
	logic host_serial_data_in;
	// Data wire floats low through the pull-down when undriven
	assign host_serial_data_in = data_oe ? data_o : 1'b0;
	modport dev (input bclk, input ws, output data_o, output data_oe);
	modport host (output bclk, output ws, input host_serial_data_in);
endinterface

// ===== verilog/mic_dev.sv
// Microphone end: samples the link clock, decimates, shifts words out.
// Assumes the master drives bit clock and strobe per the link framing.
`timescale 1ns/1ps
`include "mic_regs.svh"
module mic_dev #(
	// Wake settle count; a short bench may lower it to reach active mode
	parameter int WAKE_CYC = `MIC_WAKE_CYC
) (
	input wire logic clock,
	input wire logic rstn,
	mic_if.dev link,
	input wire logic slot_sel,
	input wire logic pdm_in,
	output mic_pkg::mic_mode_t mode,
	output logic sample_valid
);
	import mic_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [2:0] bclk_sync_reg, ws_sync_reg, sel_sync_reg;
	logic bclk_q_reg, ws_q_reg, sel_q_reg;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bclk_sync_reg <= 3'h0;
			ws_sync_reg <= 3'h0;
			sel_sync_reg <= 3'h0;
			bclk_q_reg <= 1'b0;
			ws_q_reg <= 1'b0;
			sel_q_reg <= 1'b0;
		end else begin
			bclk_sync_reg <= {bclk_sync_reg[1:0], link.bclk};
			ws_sync_reg <= {ws_sync_reg[1:0], link.ws};
			sel_sync_reg <= {sel_sync_reg[1:0], slot_sel};
			// Accept a change once stages two and three agree
			if (bclk_sync_reg[1] == bclk_sync_reg[2])
				bclk_q_reg <= bclk_sync_reg[2];
			if (ws_sync_reg[1] == ws_sync_reg[2])
				ws_q_reg <= ws_sync_reg[2];
			if (sel_sync_reg[1] == sel_sync_reg[2])
				sel_q_reg <= sel_sync_reg[2];
		end
	end

	logic bclk_d_reg;
	logic rise, fall;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			bclk_d_reg <= 1'b0;
		else
			bclk_d_reg <= bclk_q_reg;
	end
	assign rise = bclk_q_reg & ~bclk_d_reg;
	assign fall = ~bclk_q_reg & bclk_d_reg;

	// ----------------------------------------
	// Clock rate monitor and mode machine
	// ----------------------------------------
	// Counts system cycles between rising edges; also runs while stopped
	logic [15:0] per_reg, per_next;
	logic [20:0] wake_reg, wake_next;
	mic_mode_t mode_reg, mode_next;
	always_comb begin
		per_next = per_reg;
		wake_next = wake_reg;
		mode_next = mode_reg;
		if (rise)
			per_next = 16'h0;
		else if (per_reg != 16'hffff)
			per_next = per_reg + 16'h1;
		case (mode_reg)
			MIC_SLEEP: begin
				// Fast clock seen: begin wake-up
				if (rise && per_reg < 16'(`MIC_ACTIVE_CYC)) begin
					mode_next = MIC_WAKE;
					wake_next = 21'h0;
				end
			end
			MIC_WAKE: begin
				wake_next = wake_reg + 21'h1;
				if (per_reg >= 16'(`MIC_SLEEP_CYC))
					mode_next = MIC_SLEEP;
				else if (wake_reg >= 21'(WAKE_CYC - 1))
					mode_next = MIC_ACTIVE;
			end
			MIC_ACTIVE: begin
				if (per_reg >= 16'(`MIC_SLEEP_CYC))
					mode_next = MIC_SLEEP;
			end
			default: mode_next = MIC_SLEEP;
		endcase
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			per_reg <= 16'hffff;
			wake_reg <= 21'h0;
			mode_reg <= MIC_SLEEP;
		end else begin
			per_reg <= per_next;
			wake_reg <= wake_next;
			mode_reg <= mode_next;
		end
	end

	// ----------------------------------------
	// Decimator: 64 modulator bits per sample
	// ----------------------------------------
	// Modulator bit taken once per bit clock; boxcar sum acts as low-pass
	logic [6:0] ones_reg, ones_next;
	logic [5:0] dcnt_reg, dcnt_next;
	logic [17:0] pcm_reg, pcm_next;
	logic valid_reg, valid_next;
	always_comb begin
		ones_next = ones_reg;
		dcnt_next = dcnt_reg;
		pcm_next = pcm_reg;
		valid_next = 1'b0;
		if (rise && mode_reg != MIC_SLEEP) begin
			dcnt_next = dcnt_reg + 6'h1;
			if (dcnt_reg == 6'(`MIC_DECIM - 1)) begin
				// Map 0..64 ones to signed -32..+32, scaled into 18 bits
				pcm_next = {7'(ones_reg + {6'h0, pdm_in} - 7'h20), 11'h0};
				ones_next = 7'h0;
				valid_next = 1'b1;
			end else begin
				ones_next = ones_reg + {6'h0, pdm_in};
			end
		end
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ones_reg <= 7'h0;
			dcnt_reg <= 6'h0;
			pcm_reg <= 18'h0;
			valid_reg <= 1'b0;
		end else begin
			ones_reg <= ones_next;
			dcnt_reg <= dcnt_next;
			pcm_reg <= pcm_next;
			valid_reg <= valid_next;
		end
	end

	// ----------------------------------------
	// Serialiser and tri-state control
	// ----------------------------------------
	// Strobe change seen at rising edge; data moves after rising edge
	logic ws_last_reg, ws_last_next;
	logic [5:0] bit_reg, bit_next;
	mic_word_t shift_reg, shift_next;
	logic dout_reg, dout_next;
	logic oe_reg, oe_next;
	logic mine;
	always_comb begin
		ws_last_next = ws_last_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		dout_next = dout_reg;
		oe_next = oe_reg;
		// Own half: slot high takes strobe high, slot low strobe low
		mine = (ws_q_reg == sel_q_reg);
		if (rise) begin
			ws_last_next = ws_q_reg;
			if (ws_q_reg != ws_last_reg) begin
				// First rise after strobe edge puts out the MSB
				bit_next = 6'h1;
				shift_next = {pcm_reg, 6'h0};
				dout_next = pcm_reg[17];
			end else begin
				bit_next = bit_reg + 6'h1;
				if (bit_reg < 6'(`MIC_WORD_BITS)) begin
					dout_next = shift_reg[22];
					shift_next = {shift_reg[22:0], 1'b0};
				end else begin
					dout_next = 1'b0;
				end
			end
			oe_next = mine && mode_reg == MIC_ACTIVE;
		end
		// Pin released at once on sleep or slot change
		if (mode_reg != MIC_ACTIVE || !mine)
			oe_next = 1'b0;
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ws_last_reg <= 1'b0;
			bit_reg <= 6'h0;
			shift_reg <= 24'h0;
			dout_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			ws_last_reg <= ws_last_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			dout_reg <= dout_next;
			oe_reg <= oe_next;
		end
	end

	// Device drives only the data wire and its enable on the link
	assign link.data_o = dout_reg;
	assign link.data_oe = oe_reg;
	assign mode = mode_reg;
	assign sample_valid = valid_reg;
endmodule

// ===== verilog/mic_host.sv
// Bus master end: makes bit clock and strobe, captures both slots.
// Assumes the data wire reads low when nobody drives it.
`timescale 1ns/1ps
`include "mic_regs.svh"
module mic_host (
	input wire logic clock,
	input wire logic rstn,
	mic_if.host link,
	input wire logic run,
	output mic_pkg::mic_word_t left_word,
	output mic_pkg::mic_word_t right_word,
	output logic word_strobe
);
	import mic_pkg::*;

	// ----------------------------------------
	// Clock and strobe generation
	// ----------------------------------------
	logic [2:0] div_reg, div_next;
	logic bclk_reg, bclk_next;
	logic ws_reg, ws_next;
	logic [5:0] cnt_reg, cnt_next;
	logic [2:0] din_sync_reg;
	logic din_q_reg;
	mic_word_t sh_reg, sh_next, left_reg, left_next, right_reg, right_next;
	logic stb_reg, stb_next;
	always_comb begin
		div_next = div_reg;
		bclk_next = bclk_reg;
		ws_next = ws_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		left_next = left_reg;
		right_next = right_reg;
		stb_next = 1'b0;
		if (run) begin
			div_next = div_reg + 3'h1;
			if (div_reg == 3'(`MIC_HOST_HALF - 1)) begin
				div_next = 3'h0;
				bclk_next = ~bclk_reg;
				if (bclk_reg) begin
					// Falling edge: count bits, move strobe
					cnt_next = cnt_reg + 6'h1;
					ws_next = (cnt_next >= 6'(`MIC_HALF_BITS));
					// Capture bit; word of a slot is bits 1..24
					if (cnt_reg[4:0] >= 5'h1 && cnt_reg[4:0] <= 5'(`MIC_WORD_BITS))
						sh_next = {sh_reg[22:0], din_q_reg};
					if (cnt_reg[4:0] == 5'(`MIC_WORD_BITS)) begin
						if (cnt_reg[5])
							right_next = {sh_reg[22:0], din_q_reg};
						else
							left_next = {sh_reg[22:0], din_q_reg};
						stb_next = cnt_reg[5];
					end
				end
			end
		end
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			div_reg <= 3'h0;
			bclk_reg <= 1'b0;
			ws_reg <= 1'b0;
			cnt_reg <= 6'h0;
			din_sync_reg <= 3'h0;
			din_q_reg <= 1'b0;
			sh_reg <= 24'h0;
			left_reg <= 24'h0;
			right_reg <= 24'h0;
			stb_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			bclk_reg <= bclk_next;
			ws_reg <= ws_next;
			cnt_reg <= cnt_next;
			din_sync_reg <= {din_sync_reg[1:0], link.host_serial_data_in};
			// Data pin is foreign: a change counts once stages two and three agree
			if (din_sync_reg[1] == din_sync_reg[2])
				din_q_reg <= din_sync_reg[2];
			sh_reg <= sh_next;
			left_reg <= left_next;
			right_reg <= right_next;
			stb_reg <= stb_next;
		end
	end

	assign link.bclk = bclk_reg;
	assign link.ws = ws_reg;
	assign left_word = left_reg;
	assign right_word = right_reg;
	assign word_strobe = stb_reg;
endmodule

// ===== testbench/mic_link_asserts.sv
// Checks on the link wires: framing, bit clock rate, pin release.
// Assumes the testbench instantiates it beside the link interface.
`timescale 1ns/1ps
module mic_link_asserts (
	input wire logic clock,
	input wire logic rstn,
	input wire logic bclk,
	input wire logic ws,
	input wire logic data_o,
	input wire logic data_oe
);
	// ------------------------------
	// Helper counters
	// ------------------------------
	logic bclk_reg, bclk_next, ws_reg, ws_next;
	logic [5:0] rise_reg, rise_next;
	logic [15:0] idle_reg, idle_next;
	logic [7:0] gap_reg, gap_next;
	// Rises per half-frame, cycles since any edge, cycles since last rise
	always_comb begin
		bclk_next = bclk;
		ws_next = ws;
		rise_next = (ws != ws_reg) ? 6'h00 : rise_reg + {5'h00, bclk & ~bclk_reg};
		idle_next = (bclk != bclk_reg) ? 16'h0000 : idle_reg + {15'h0000, idle_reg != 16'hffff};
		gap_next = (bclk & ~bclk_reg) ? 8'h00 : gap_reg + {7'h00, gap_reg != 8'hff};
	end
	// Gap starts saturated so a first rise is not timed
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bclk_reg <= 1'b0;
			ws_reg <= 1'b0;
			rise_reg <= 6'h00;
			idle_reg <= 16'h0000;
			gap_reg <= 8'hff;
		end else begin
			bclk_reg <= bclk_next;
			ws_reg <= ws_next;
			rise_reg <= rise_next;
			idle_reg <= idle_next;
			gap_reg <= gap_next;
		end
	end
	// ------------------------------
	// Properties
	// ------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_ws_edge;
		$changed(ws);
	endsequence
	sequence s_fast_rise;
		$rose(bclk) && gap_reg < 8'd100;
	endsequence
	property p_ws_on_fall;
		s_ws_edge |-> $fell(bclk);
	endproperty
	property p_ws_rate;
		s_ws_edge |-> rise_reg == 6'd32;
	endproperty
	property p_half_bound;
		rise_reg <= 6'd32;
	endproperty
	property p_bclk_period;
		s_fast_rise |-> gap_reg == 8'd7;
	endproperty
	property p_own_half;
		s_ws_edge |-> ##5 !data_oe;
	endproperty
	property p_fast_only;
		$rose(data_oe) |-> gap_reg < 8'd25;
	endproperty
	property p_sleep_release;
		idle_reg >= 16'd25010 |-> !data_oe;
	endproperty
	property p_tail_zero;
		data_oe && rise_reg >= 6'd20 |-> !data_o;
	endproperty
	a_ws_on_fall: assert property (p_ws_on_fall) else $error("strobe moved off a falling edge");
	a_ws_rate: assert property (p_ws_rate) else $error("half-frame not 32 rises");
	a_half_bound: assert property (p_half_bound) else $error("half-frame too long");
	a_bclk_period: assert property (p_bclk_period) else $error("bit clock period wrong");
	a_own_half: assert property (p_own_half) else $error("pin held into next half");
	a_fast_only: assert property (p_fast_only) else $error("pin driven on slow clock");
	a_sleep_release: assert property (p_sleep_release) else $error("pin driven when stopped");
	a_tail_zero: assert property (p_tail_zero) else $error("low bits not zero");
endmodule

// ===== testbench/testbench.sv
// Testbench joining both link ends through the link interface.
// Assumes 25 MHz clock; wake settle is shortened so active mode is reached.
`timescale 1ns/1ps
module testbench;
	import mic_pkg::*;
	typedef struct packed {logic run; logic slot; logic pdm; logic [15:0] cyc; mic_mode_t mode;} mic_row_t;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic run = 1'b0;
	logic slot_sel = 1'b0;
	logic pdm_in = 1'b0;
	logic sample_valid, word_strobe, seen;
	mic_mode_t mode;
	mic_word_t left_word, right_word;
	int mismatches = 0;
	int num_checks = 0;
	int nvalid;
	mic_row_t rows [5];
	mic_if link ();
	always #20 clock = ~clock;
	// Short wake settle keeps the run brief; the length itself is a plain count
	mic_dev #(.WAKE_CYC(2000)) mic_dev_inst (.clock(clock), .rstn(rstn), .link(link), .slot_sel(slot_sel),
		.pdm_in(pdm_in),
		.mode(mode), .sample_valid(sample_valid));
	mic_host mic_host_inst (.clock(clock), .rstn(rstn), .link(link), .run(run), .left_word(left_word),
		.right_word(right_word), .word_strobe(word_strobe));
	mic_link_asserts mic_link_asserts_inst (.clock(clock), .rstn(rstn), .bclk(link.bclk), .ws(link.ws),
		.data_o(link.data_o), .data_oe(link.data_oe));
	// ------------------------------
	// Compare and closing tasks
	// ------------------------------
	task automatic report(input logic ok, input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (!ok) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_word(input mic_word_t got, input mic_word_t exp);
		report(got === exp, got, exp);
	endtask
	task automatic check_mode(input mic_mode_t got, input mic_mode_t exp);
		report(got === exp, {22'h000000, got}, {22'h000000, exp});
	endtask
	task automatic check_bit(input logic got, input logic exp);
		report(got === exp, {23'h000000, got}, {23'h000000, exp});
	endtask
	task automatic check_count(input int got, input int exp);
		report(got == exp, 24'(got), 24'(exp));
	endtask
	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Bounded wait for the host's word pulse, sampled off the edge
	// Also counts new-sample pulses seen on the way
	task automatic wait_strobe(output logic found, output int valids);
		found = 1'b0;
		valids = 0;
		for (int n = 0; n < 1200 && !found; n++) begin
			@(negedge clock);
			found = (word_strobe === 1'b1);
			valids += (sample_valid === 1'b1) ? 1 : 0;
		end
	endtask
	// Steady input into one slot; five frames let wake and filter settle
	task automatic data_case(input logic slot, input logic pdm, input mic_word_t exp_l, input mic_word_t exp_r);
		logic found;
		int nv;
		@(posedge clock);
		slot_sel <= slot;
		pdm_in <= pdm;
		repeat (5) wait_strobe(found, nv);
		check_bit(found, 1'b1);
		check_count(nv, 1);
		check_mode(mode, MIC_ACTIVE);
		check_word(left_word, exp_l);
		check_word(right_word, exp_r);
	endtask
	// ------------------------------
	// Main sequence
	// ------------------------------
	// Stopping for over 1 ms must put the device back to sleep
	initial begin
		rows[0] = '{1'b0, 1'b0, 1'b0, 16'd20, MIC_SLEEP};
		rows[1] = '{1'b1, 1'b0, 1'b1, 16'd600, MIC_WAKE};
		rows[2] = '{1'b1, 1'b1, 1'b0, 16'd1100, MIC_WAKE};
		rows[3] = '{1'b0, 1'b1, 1'b1, 16'd25100, MIC_SLEEP};
		rows[4] = '{1'b1, 1'b0, 1'b0, 16'd600, MIC_WAKE};
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			@(posedge clock);
			run <= rows[i].run;
			slot_sel <= rows[i].slot;
			pdm_in <= rows[i].pdm;
			repeat (rows[i].cyc) @(posedge clock);
			@(negedge clock);
			check_mode(mode, rows[i].mode);
			check_bit(link.data_oe, 1'b0);
			check_word(left_word, 24'h000000);
		end
		// Frames keep coming while the device settles; slot 1 reads floating low
		@(posedge clock);
		slot_sel <= 1'b1;
		wait_strobe(seen, nvalid);
		check_bit(seen, 1'b1);
		check_word(right_word, 24'h000000);
		// Settled: all-ones input in slot 1, then all-zeros input in slot 0
		data_case(1'b1, 1'b1, 24'h000000, 24'h400000);
		data_case(1'b0, 1'b0, 24'hc00000, 24'h000000);
		// Clock stopped in the right half, where slot 0 has already released the pin: stay released and sleep
		@(posedge clock);
		run <= 1'b0;
		repeat (25100) @(posedge clock);
		@(negedge clock);
		check_mode(mode, MIC_SLEEP);
		check_bit(link.data_oe, 1'b0);
		// Reset in mid-run returns both ends to idle
		@(posedge clock);
		run <= 1'b1;
		repeat (300) @(posedge clock);
		rstn <= 1'b0;
		repeat (8) @(posedge clock);
		@(negedge clock);
		check_mode(mode, MIC_SLEEP);
		check_bit(link.bclk, 1'b0);
		check_bit(link.ws, 1'b0);
		check_bit(link.data_oe, 1'b0);
		@(posedge clock);
		rstn <= 1'b1;
		repeat (600) @(posedge clock);
		@(negedge clock);
		check_mode(mode, MIC_WAKE);
		finish_test();
	end
	// Watchdog: about one and a half times the expected run
	initial begin
		#3600000;
		mismatches++;
		finish_test();
	end
endmodule
